/* rtl/timer16_irq_pkg.sv */
// package: register map, field layout and carrier types of the timer irq block
package timer16_irq_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] CAPTURE_VALUE1_LOW = 8'h46;
   localparam logic [7:0] CAPTURE_VALUE1_HIGH = 8'h47;
   localparam logic [7:0] CAPTURE_VALUE3_LOW = 8'h80;
   localparam logic [7:0] TIMER_IRQ_FLAGS = 8'h56;
   localparam logic [7:0] TIMER_IRQ_MASK = 8'h57;
   localparam logic [7:0] EXT_TIMER_IRQ_FLAGS = 8'h7c;
   localparam logic [7:0] EXT_TIMER_IRQ_MASK = 8'h7d;
   localparam logic [7:0] COMPARE_VALUE1A_LOW = 8'h4a;
   localparam logic [7:0] COMPARE_VALUE1B_LOW = 8'h48;
   localparam logic [7:0] COMPARE_VALUE1C_LOW = 8'h78;
   localparam logic [7:0] COMPARE_VALUE3A_LOW = 8'h86;
   localparam logic [7:0] COMPARE_VALUE3B_LOW = 8'h84;
   localparam logic [7:0] COMPARE_VALUE3C_LOW = 8'h82;
   localparam logic [7:0] COMPARE_VALUE3C_HIGH = 8'h83;

   // ****************************************
   // 16-bit register slots: 0..5 compare 1a,1b,1c,3a,3b,3c; 6,7 capture 1,3
   // ****************************************
   localparam int NUM_W16 = 8;
   localparam int FIRST_CAP = 6;
   localparam logic [7:0][7:0] W16_LOW_OFFSET = {
      CAPTURE_VALUE3_LOW, CAPTURE_VALUE1_LOW, COMPARE_VALUE3C_LOW, COMPARE_VALUE3B_LOW,
      COMPARE_VALUE3A_LOW, COMPARE_VALUE1C_LOW, COMPARE_VALUE1B_LOW, COMPARE_VALUE1A_LOW};

   // ****************************************
   // flag and mask bit positions (same layout in flag and mask registers)
   // ****************************************
   localparam int CAPTURE_BIT = 5;
   localparam int CMPA_BIT = 4;
   localparam int CMPB_BIT = 3;
   localparam int OVF_BIT = 2;
   localparam int CMPC3_BIT = 1;
   localparam int CMPC1_BIT = 0;
   localparam logic [7:0] T1_IMPL_BITS = 8'h3c;
   localparam logic [7:0] EXT_IMPL_BITS = 8'h3f;

   // waveform modes in which capture_value is the top: 8, 10, 12, 14
   localparam logic [15:0] CAPTURE_TOP_MODES = 16'h5500;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] W16_RESET = 16'h0000;

   // ****************************************
   // carrier types
   // ****************************************
   typedef struct packed {
      logic [15:0] counter_value;
      logic tick;
      logic ovf_evt;
      logic top_reached;
      logic capture_pin;
      logic capture_rise;
      logic [3:0] waveform_mode_select;
   } unit_in_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr_en;
      logic rd_en;
   } reg_req_t;

endpackage

/* rtl/timer16_irq.sv */
// module: capture/compare holding registers, shared byte latch and timer interrupt flags
`timescale 1ns/1ps

// Functional notes
// - each compare register is compared against its unit counter on each timer tick
// - compare writes stage the upper byte in one shared latch, land together
// - capture register loads counter on capture edge; unit 1 may use comparator
// - capture register can be chosen as counter top value
// - capture reads take low byte and park high byte in shared latch
// - interrupt requested only with mask bit, global enable and flag set
// - unit 1 mask bits: capture 5, cmpa 4, cmpb 3, overflow 2
// - extended mask: cap3 5, cmpa3 4, cmpb3 3, ovf3 2, cmpc3 1, cmpc1 0
// - extended mask register absent while legacy compatibility fuse is active
// - unit 1 flags: capture 5, cmpa 4, cmpb 3, overflow 2
// - capture flag on capture event, or on reaching top when capture is top
// - compare flag set in the timer clock cycle after the match
// - forced compare strobes never touch compare flags
// - overflow flag set when counter overflows, as the counter reports it
// - flags clear on vector execution or on writing one; zero does nothing
module timer16_irq (
   input wire logic core_clk,
   input wire logic rstn,
   input timer16_irq_pkg::reg_req_t req,
   output logic [7:0] rdata,
   input wire logic global_interrupt_enable,
   input wire logic compat_mode,
   input timer16_irq_pkg::unit_in_t [1:0] unit_in,
   input wire logic acomp_out,
   input wire logic acomp_sel,
   input wire logic [5:0] force_cmp,
   input wire logic [15:0] vector_ack,
   output logic [15:0] irq_req,
   output logic irq,
   output logic [5:0] cmp_match,
   output logic [5:0] compare_output_pin,
   output logic [1:0] capture_top,
   output logic [1:0][15:0] capture_value
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] shared_high_byte_latch;
      logic [timer16_irq_pkg::NUM_W16-1:0][15:0] w16;
      logic [7:0] timer_irq_mask;
      logic [7:0] ext_timer_irq_mask;
      logic [7:0] timer_irq_flags;
      logic [7:0] ext_timer_irq_flags;
      logic [15:0] irq_req;
      logic irq;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [1:0] src;
   logic [1:0] cap_evt;
   logic [1:0] cap_flag_evt;
   logic [5:0] cmp_set;
   logic [7:0] set1;
   logic [7:0] setx;
   logic [7:0] clr1;
   logic [7:0] clrx;
   logic [7:0] eff_xmask;
   logic [15:0] req_all;

   // ****************************************
   // capture sources and channels
   // ****************************************
   // unit 1 may take the comparator in place of its pin
   assign src[0] = acomp_sel ? acomp_out : unit_in[0].capture_pin;
   assign src[1] = unit_in[1].capture_pin;

   for (genvar u = 0; u < 2; u++) begin : g_cap
      capture_channel chan (
         .core_clk(core_clk),
         .rstn(rstn),
         .src(src[u]),
         .capture_rise(unit_in[u].capture_rise),
         .top_reached(unit_in[u].top_reached),
         .waveform_mode_select(unit_in[u].waveform_mode_select),
         .cap_evt(cap_evt[u]),
         .cap_flag_evt(cap_flag_evt[u]),
         .capture_top(capture_top[u])
      );
   end

   // ****************************************
   // compare channels: 1a, 1b, 1c on unit 1, then 3a, 3b, 3c on unit 3
   // ****************************************
   // channels see the stored value, so a fresh compare value acts one cycle late
   for (genvar i = 0; i < 6; i++) begin : g_cmp
      compare_channel #(
         .WIDTH(16)
      ) chan (
         .core_clk(core_clk),
         .rstn(rstn),
         .tick(unit_in[i / 3].tick),
         .counter_value(unit_in[i / 3].counter_value),
         .compare_value(state_reg.w16[i]),
         .force_strobe(force_cmp[i]),
         .match_set(cmp_set[i]),
         .match_pulse(cmp_match[i]),
         .pin(compare_output_pin[i])
      );
   end

   always_comb begin
      state_next = state_reg;
      state_next.rdata = timer16_irq_pkg::REG_RESET;
      clr1 = 8'h00;
      clrx = 8'h00;

      // ****************************************
      // register writes and reads
      // ****************************************
      for (int k = 0; k < timer16_irq_pkg::NUM_W16; k++) begin
         if (req.wr_en && req.addr == timer16_irq_pkg::W16_LOW_OFFSET[k] + 8'h01) begin
            state_next.shared_high_byte_latch = req.wdata;
         end
         if (req.wr_en && req.addr == timer16_irq_pkg::W16_LOW_OFFSET[k]) begin
            state_next.w16[k] = {state_reg.shared_high_byte_latch, req.wdata};
         end
         if (req.rd_en && req.addr == timer16_irq_pkg::W16_LOW_OFFSET[k]) begin
            state_next.rdata = state_reg.w16[k][7:0];
            state_next.shared_high_byte_latch = state_reg.w16[k][15:8];
         end
         if (req.rd_en && req.addr == timer16_irq_pkg::W16_LOW_OFFSET[k] + 8'h01) begin
            state_next.rdata = state_reg.shared_high_byte_latch;
         end
      end

      // capture wins over a software write to the low byte in the same cycle
      for (int u = 0; u < 2; u++) begin
         if (cap_evt[u]) begin
            state_next.w16[timer16_irq_pkg::FIRST_CAP + u] = unit_in[u].counter_value;
         end
      end

      if (req.wr_en) begin
         case (req.addr)
            timer16_irq_pkg::TIMER_IRQ_MASK: begin
               state_next.timer_irq_mask = req.wdata & timer16_irq_pkg::T1_IMPL_BITS;
            end
            timer16_irq_pkg::EXT_TIMER_IRQ_MASK: begin
               if (!compat_mode) begin
                  state_next.ext_timer_irq_mask = req.wdata &
                     timer16_irq_pkg::EXT_IMPL_BITS;
               end
            end
            timer16_irq_pkg::TIMER_IRQ_FLAGS: begin
               clr1 = req.wdata & timer16_irq_pkg::T1_IMPL_BITS;
            end
            timer16_irq_pkg::EXT_TIMER_IRQ_FLAGS: begin
               clrx = req.wdata & timer16_irq_pkg::EXT_IMPL_BITS;
            end
            default: begin
            end
         endcase
      end

      if (req.rd_en) begin
         case (req.addr)
            timer16_irq_pkg::TIMER_IRQ_MASK: begin
               state_next.rdata = state_reg.timer_irq_mask;
            end
            timer16_irq_pkg::EXT_TIMER_IRQ_MASK: begin
               // absent in compatibility mode: reads as zero
               state_next.rdata = compat_mode ? 8'h00 : state_reg.ext_timer_irq_mask;
            end
            timer16_irq_pkg::TIMER_IRQ_FLAGS: begin
               state_next.rdata = state_reg.timer_irq_flags;
            end
            timer16_irq_pkg::EXT_TIMER_IRQ_FLAGS: begin
               state_next.rdata = state_reg.ext_timer_irq_flags;
            end
            default: begin
            end
         endcase
      end

      // ****************************************
      // interrupt flags
      // ****************************************
      set1 = 8'h00;
      set1[timer16_irq_pkg::CAPTURE_BIT] = cap_flag_evt[0];
      set1[timer16_irq_pkg::CMPA_BIT] = cmp_set[0];
      set1[timer16_irq_pkg::CMPB_BIT] = cmp_set[1];
      set1[timer16_irq_pkg::OVF_BIT] = unit_in[0].ovf_evt;
      setx = 8'h00;
      setx[timer16_irq_pkg::CAPTURE_BIT] = cap_flag_evt[1];
      setx[timer16_irq_pkg::CMPA_BIT] = cmp_set[3];
      setx[timer16_irq_pkg::CMPB_BIT] = cmp_set[4];
      setx[timer16_irq_pkg::OVF_BIT] = unit_in[1].ovf_evt;
      setx[timer16_irq_pkg::CMPC3_BIT] = cmp_set[5];
      setx[timer16_irq_pkg::CMPC1_BIT] = cmp_set[2];

      clr1 = clr1 | vector_ack[7:0];
      clrx = clrx | vector_ack[15:8];
      // set is applied after clear so a coincident event survives
      state_next.timer_irq_flags = ((state_reg.timer_irq_flags & ~clr1) | set1) &
         timer16_irq_pkg::T1_IMPL_BITS;
      state_next.ext_timer_irq_flags = ((state_reg.ext_timer_irq_flags & ~clrx) | setx) &
         timer16_irq_pkg::EXT_IMPL_BITS;

      // ****************************************
      // interrupt requests
      // ****************************************
      eff_xmask = compat_mode ? 8'h00 : state_next.ext_timer_irq_mask;
      req_all = {state_next.ext_timer_irq_flags & eff_xmask,
                 state_next.timer_irq_flags & state_next.timer_irq_mask};
      state_next.irq_req = global_interrupt_enable ? req_all : 16'h0000;
      state_next.irq = global_interrupt_enable && (req_all != 16'h0000);
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign irq_req = state_reg.irq_req;
   assign irq = state_reg.irq;
   assign capture_value = state_reg.w16[timer16_irq_pkg::NUM_W16-1:timer16_irq_pkg::FIRST_CAP];

endmodule

// ****************************************
// capture edge detector and top selection of one unit
// ****************************************
module capture_channel (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic src,
   input wire logic capture_rise,
   input wire logic top_reached,
   input wire logic [3:0] waveform_mode_select,
   output logic cap_evt,
   output logic cap_flag_evt,
   output logic capture_top
);

   typedef struct packed {
      logic src_prev;
      logic capture_top;
   } cap_state_t;

   cap_state_t cap_reg;
   cap_state_t cap_next;
   logic top_sel;

   always_comb begin
      cap_next = cap_reg;
      top_sel = timer16_irq_pkg::CAPTURE_TOP_MODES[waveform_mode_select];
      // the pin is disconnected while capture_value defines the period
      // reset clears the old level, so a pin already high gives one rising edge
      cap_evt = !top_sel && (capture_rise ? (src && !cap_reg.src_prev) :
         (!src && cap_reg.src_prev));
      // in top modes the flag marks the period end instead of a capture
      cap_flag_evt = top_sel ? top_reached : cap_evt;
      cap_next.src_prev = src;
      // registered, so the top choice shows one cycle after the mode changes
      cap_next.capture_top = top_sel;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cap_reg <= '0;
      end else begin
         cap_reg <= cap_next;
      end
   end

   assign capture_top = cap_reg.capture_top;

endmodule

// ****************************************
// one compare channel: match detect, flag event and pin
// ****************************************
module compare_channel #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic [WIDTH-1:0] counter_value,
   input wire logic [WIDTH-1:0] compare_value,
   input wire logic force_strobe,
   output logic match_set,
   output logic match_pulse,
   output logic pin
);

   typedef struct packed {
      logic hit;
      logic match_pulse;
      logic pin;
   } chan_state_t;

   chan_state_t chan_reg;
   chan_state_t chan_next;

   always_comb begin
      chan_next = chan_reg;
      // equality is taken on one timer tick, the flag lands on the next
      // hit is held between ticks so a slow timer still flags exactly once
      match_set = tick && chan_reg.hit;
      if (tick) begin
         chan_next.hit = counter_value == compare_value;
      end
      // a forced strobe moves the pin and match pulse but never reaches the flags
      chan_next.match_pulse = match_set || force_strobe;
      // toggle only: no set, clear or pwm shaping of the pin here
      if (match_set || force_strobe) begin
         chan_next.pin = !chan_reg.pin;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         chan_reg <= '0;
      end else begin
         chan_reg <= chan_next;
      end
   end

   // match_set stays combinational: the flag logic registers it with the other events
   assign match_pulse = chan_reg.match_pulse;
   assign pin = chan_reg.pin;

endmodule

/* test/timer_unit_model.sv */
// partner model: counter unit feeding one timer input bundle
`timescale 1ns/1ps
module timer_unit_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic pin,
   input wire logic [3:0] mode,
   input wire logic top_pulse,
   output timer16_irq_pkg::unit_in_t unit
);
   // ****************************************
   // count, wrap and report
   // ****************************************
   logic [15:0] cnt_reg;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cnt_reg <= 16'h0000;
      end else if (load) begin
         cnt_reg <= load_val;
      end else if (run) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   // one timer tick per clock while running; overflow as the count leaves the top
   assign unit = '{cnt_reg, run, run && cnt_reg == 16'hffff, top_pulse, pin, 1'b1, mode};
endmodule

/* test/timer16_irq_props.sv */
// checker: port properties of the timer irq block
`timescale 1ns/1ps
module timer16_irq_props (
   input wire logic core_clk,
   input wire logic rstn,
   input timer16_irq_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic global_interrupt_enable,
   input wire logic compat_mode,
   input timer16_irq_pkg::unit_in_t [1:0] unit_in,
   input wire logic acomp_sel,
   input wire logic [5:0] force_cmp,
   input wire logic [15:0] vector_ack,
   input wire logic [15:0] irq_req,
   input wire logic irq,
   input wire logic [5:0] cmp_match,
   input wire logic [1:0] capture_top,
   input wire logic [1:0][15:0] capture_value
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence s_ovf_vs_ack;
      irq_req[2] && vector_ack[2] && unit_in[0].ovf_evt && global_interrupt_enable && !req.wr_en;
   endsequence
   AST_IRQ_GIE: assert property (irq_req != 16'h0000 |-> $past(global_interrupt_enable))
      else $error("irq request without global enable");
   AST_IRQ_ANY: assert property (irq == (irq_req != 16'h0000))
      else $error("irq line disagrees with requests");
   AST_RSV_IRQ: assert property (irq_req[15:14] == 2'b00 && irq_req[7:6] == 2'b00)
      else $error("request on reserved flag bit");
   AST_EXT_RSV: assert property (req.rd_en && req.addr == 8'h7d |=> rdata[7:6] == 2'b00)
      else $error("ext mask reserved bits not zero");
   AST_COMPAT: assert property (req.rd_en && req.addr == 8'h7d && compat_mode |=> rdata == 8'h00)
      else $error("ext mask visible in compat mode");
   AST_FORCE: assert property (force_cmp[1] |=> cmp_match[1])
      else $error("forced compare gave no match pulse");
   AST_W1C: assert property (req.wr_en && req.addr == 8'h56 && req.wdata[2]
      && !unit_in[0].ovf_evt |=> !irq_req[2]) else $error("write one left flag set");
   AST_SET_WINS: assert property (s_ovf_vs_ack |=> irq_req[2])
      else $error("overflow lost to same-cycle clear");
   AST_CAP_TOP: assert property ($past(rstn) |-> capture_top[0] ==
      timer16_irq_pkg::CAPTURE_TOP_MODES[$past(unit_in[0].waveform_mode_select)])
      else $error("capture top does not follow mode");
   AST_CAPTURE: assert property (!acomp_sel && $rose(unit_in[0].capture_pin)
      && !timer16_irq_pkg::CAPTURE_TOP_MODES[unit_in[0].waveform_mode_select]
      |=> capture_value[0] == $past(unit_in[0].counter_value)) else $error("capture missed");
endmodule
bind timer16_irq timer16_irq_props chk (.core_clk, .rstn, .req, .rdata, .global_interrupt_enable,
   .compat_mode, .unit_in, .acomp_sel, .force_cmp, .vector_ack, .irq_req, .irq, .cmp_match,
   .capture_top, .capture_value);

/* test/timer16_irq_capture_compare_regs_tb_top.sv */
// testbench: register access, flags and capture paths of the timer irq block
`timescale 1ns/1ps
module timer16_irq_capture_compare_regs_tb_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic gie = 1'b0, compat = 1'b0, acmp = 1'b0, asel = 1'b0, irq;
   logic [1:0] run = '0, load = '0, pin = '0, top = '0, capture_top;
   logic [1:0][15:0] lval = '0, capture_value;
   logic [1:0][3:0] mode = '0;
   logic [5:0] force_cmp = '0, cmp_match, cmp_pin;
   logic [15:0] vack = '0, irq_req;
   logic [7:0] rdata;
   logic [7:0] offs [8] = '{8'h46, 8'h47, 8'h56, 8'h57, 8'h7d, 8'h82, 8'h83, 8'h5f};
   timer16_irq_pkg::reg_req_t req = '0;
   timer16_irq_pkg::unit_in_t [1:0] unit_in;
   int fail_count = 0;
   int samples_checked = 0;
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   for (genvar i = 0; i < 2; i++) begin : g_unit
      timer_unit_model m (.core_clk(core_clk), .rstn(rstn), .run(run[i]), .load(load[i]),
         .load_val(lval[i]), .pin(pin[i]), .mode(mode[i]), .top_pulse(top[i]), .unit(unit_in[i]));
   end
   timer16_irq dut (.core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata),
      .global_interrupt_enable(gie), .compat_mode(compat), .unit_in(unit_in), .acomp_out(acmp),
      .acomp_sel(asel), .force_cmp(force_cmp), .vector_ack(vack), .irq_req(irq_req), .irq(irq),
      .cmp_match(cmp_match), .compare_output_pin(cmp_pin), .capture_top(capture_top),
      .capture_value(capture_value));
   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      req.wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk);
      req.rd_en <= 1'b0;
      #1;
      chk($sformatf("read %h", a), {8'h00, rdata}, {8'h00, exp});
   endtask
   // unit 1 counter: load a start value, then run or hold
   task automatic ld(input logic [15:0] v, input logic r);
      @(posedge core_clk);
      load[0] <= 1'b1;
      lval[0] <= v;
      run[0] <= r;
      @(posedge core_clk);
      load[0] <= 1'b0;
   endtask
   task automatic wait_irq(input int b);
      #1;
      for (int n = 0; irq_req[b] !== 1'b1; n++) begin
         if (n == 200) begin
            fail_count++;
            end_of_test();
         end
         tick(1);
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (offs[i]) rd(offs[i], 8'h00);
      wr(8'h83, 8'h12);
      wr(8'h82, 8'h34);
      rd(8'h82, 8'h34);
      rd(8'h83, 8'h12);
      $display("test reset and 16-bit access done");
      // move compare 1b off zero so wraps below cannot hit it
      wr(8'h49, 8'h80);
      wr(8'h48, 8'h00);
      wr(8'h4b, 8'h00);
      wr(8'h4a, 8'h10);
      wr(8'h57, 8'h3c);
      rd(8'h57, 8'h3c);
      gie <= 1'b1;
      ld(16'h0008, 1'b1);
      wait_irq(4);
      chk("count at flag", unit_in[0].counter_value, 16'h0012);
      chk("irq", {15'h0000, irq}, 16'h0001);
      @(posedge core_clk);
      run[0] <= 1'b0;
      wr(8'h56, 8'h00);
      chk("flag kept", {15'h0000, irq_req[4]}, 16'h0001);
      wr(8'h56, 8'h10);
      chk("flag cleared", {15'h0000, irq_req[4]}, 16'h0000);
      @(posedge core_clk);
      force_cmp <= 6'h02;
      @(posedge core_clk);
      force_cmp <= 6'h00;
      #1;
      chk("forced match", {15'h0000, cmp_match[1]}, 16'h0001);
      chk("forced flag", {15'h0000, irq_req[3]}, 16'h0000);
      chk("compare pins", {14'h0000, cmp_pin[1:0]}, 16'h0003);
      $display("test compare done");
      ld(16'hfffe, 1'b1);
      wait_irq(2);
      chk("ovf irq", {15'h0000, irq}, 16'h0001);
      @(posedge core_clk);
      run[0] <= 1'b0;
      gie <= 1'b0;
      rd(8'h56, 8'h04);
      chk("irq gated", {15'h0000, irq}, 16'h0000);
      @(posedge core_clk);
      gie <= 1'b1;
      ld(16'hffff, 1'b1);
      vack <= 16'h0004;
      @(posedge core_clk);
      vack <= 16'h0000;
      run[0] <= 1'b0;
      #1;
      chk("set wins", {15'h0000, irq_req[2]}, 16'h0001);
      @(posedge core_clk);
      vack <= 16'h0004;
      @(posedge core_clk);
      vack <= 16'h0000;
      #1;
      chk("vector clear", {15'h0000, irq_req[2]}, 16'h0000);
      $display("test overflow done");
      ld(16'h0234, 1'b0);
      @(posedge core_clk);
      pin[0] <= 1'b1;
      tick(1);
      chk("capture", capture_value[0], 16'h0234);
      chk("capture flag", {15'h0000, irq_req[5]}, 16'h0001);
      rd(8'h46, 8'h34);
      rd(8'h47, 8'h02);
      wr(8'h56, 8'h24);
      ld(16'h0456, 1'b0);
      asel <= 1'b1;
      @(posedge core_clk);
      acmp <= 1'b1;
      tick(1);
      chk("comparator capture", capture_value[0], 16'h0456);
      wr(8'h56, 8'h20);
      @(posedge core_clk);
      mode[0] <= 4'hc;
      @(posedge core_clk);
      top[0] <= 1'b1;
      @(posedge core_clk);
      top[0] <= 1'b0;
      tick(1);
      chk("capture top", {15'h0000, capture_top[0]}, 16'h0001);
      chk("top flag", {15'h0000, irq_req[5]}, 16'h0001);
      $display("test capture done");
      @(posedge core_clk);
      compat <= 1'b1;
      wr(8'h7d, 8'h3f);
      rd(8'h7d, 8'h00);
      @(posedge core_clk);
      compat <= 1'b0;
      wr(8'h7d, 8'h3f);
      rd(8'h7d, 8'h3f);
      @(posedge core_clk);
      pin[1] <= 1'b1;
      tick(1);
      chk("unit 3 capture irq", {15'h0000, irq_req[13]}, 16'h0001);
      rd(8'h7c, 8'h21);
      wr(8'h7c, 8'h3f);
      rd(8'h7c, 8'h00);
      $display("test extended mask done");
      end_of_test();
   end
endmodule
